// ### eccp_pkg.sv
/*
  Shared constants and types for the enhanced capture/compare/PWM core.
  Assumes a 32-bit classic Wishbone slave with byte offsets below.
*/
`default_nettype none

package eccp_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL     = 8'h00; // Unit control
  localparam logic [7:0] ADR_DUTY     = 8'h04; // Duty low byte
  localparam logic [7:0] ADR_PERIOD   = 8'h08; // Period register
  localparam logic [7:0] ADR_DEADBAND = 8'h0c; // Dead-band delay
  localparam logic [7:0] ADR_COMPARE  = 8'h10; // Compare pair
  localparam logic [7:0] ADR_TSEL     = 8'h14; // Timer select
  localparam logic [7:0] ADR_CONFIG   = 8'h18; // Pin map select
  localparam logic [7:0] ADR_STATUS   = 8'h1c; // Sticky events
  localparam logic [7:0] ADR_IRQ_EN   = 8'h20; // Event enables
  localparam logic [7:0] ADR_IRQ_CLR  = 8'h24; // Write-one clear
  localparam logic [7:0] ADR_SHADOW   = 8'h28; // Active duty

  // ==========================================================
  // Field positions and reset values
  localparam int TSEL_CCP_BIT = 0; // 1: timer three for compare
  localparam int TSEL_PWM_BIT = 1; // 1: alt period timer
  localparam int ST_CMP  = 0;      // Compare match event
  localparam int ST_PER  = 1;      // PWM period event
  localparam int ST_TRIG = 2;      // Special event trigger
  localparam int ST_W    = 3;
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;
  localparam int PIN_B_ALT = 4;
  localparam int PIN_C_ALT = 5;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [6:0] DB_MAX     = 7'h7f;

  // ==========================================================
  // Mode and output arrangement codes
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLEAR   = 4'h9;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD    = 2'h1;
  localparam logic [1:0] CFG_HALF   = 2'h2;
  localparam logic [1:0] CFG_REV    = 2'h3;

  // Unit control register layout
  typedef struct packed {
    logic [1:0] output_config_field;
    logic [1:0] duty_lsb;
    logic [3:0] mode_select_field;
  } unit_ctrl_t;

  // Pin group: level and ownership per pin
  typedef struct packed {
    logic [5:0] own;
    logic [5:0] out;
  } pins_t;

  // Special event trigger outputs
  typedef struct packed {
    logic clr_t1;
    logic clr_t3;
    logic adc_start;
    logic flag_hold;
  } trig_t;

  // PWM start-up states, Gray along the path
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_WAIT = 2'b01,
    PS_RUN  = 2'b11
  } pwm_state_t;

endpackage

`default_nettype wire

// ### eccp_core.sv
/*
  Enhanced capture/compare/PWM unit with special event trigger,
  pin routing and double-buffered PWM control.
  Assumes timers, A/D and the shared compare unit run on clk.
*/
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module eccp_core
  import eccp_pkg::*;
#(
  parameter int UNIT = 1  // Unit number 1..3
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic [7:0]  period_timer,
  input  wire logic [7:0]  alt_period_timer,
  input  wire logic        period_tick,
  input  wire logic        alt_period_tick,
  input  wire logic [1:0]  subcycle,
  input  wire logic [15:0] timer_one_count,
  input  wire logic [15:0] timer_three_count,
  input  wire logic        adc_enabled,
  input  wire logic        shared_out,
  input  wire logic        shared_own,
  output var  pins_t       pins,
  output var  trig_t       trig,
  output var  logic [1:0]  period_clear,
  output var  logic        irq
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_pipe;   // Release synchroniser
  logic       rst_sync_n; // Synchronised reset

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // ==========================================================
  // Wishbone slave
  logic        acc;      // Request pending, no ack yet
  logic        wr;       // Write takes effect now
  logic [31:0] rdata;    // Read mux
  unit_ctrl_t  unit_control_reg;
  logic [7:0]  duty_low_byte;
  logic [7:0]  period_register;
  logic [6:0]  deadband_delay_reg;
  logic [15:0] compare_value_pair;
  logic [1:0]  timer_three_control;
  logic        alt_pin_map_select;
  logic [2:0]  status;   // Sticky events
  logic [2:0]  irq_enable;
  logic [2:0]  ev;       // Events this cycle
  pwm_state_t  state;
  logic [9:0]  duty_shadow;

  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land on the edge where the master sees ack
  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // One wait state, ack drops the cycle after
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= acc;
      if (acc) begin
        wb_dat_o <= wb_we_i ? 32'h0 : rdata;
      end
    end
  end

  // Read decode; unmapped offsets answer zero
  always_comb begin
    case (wb_adr_i)
      ADR_CTRL:     rdata = {24'h0, unit_control_reg};
      ADR_DUTY:     rdata = {24'h0, duty_low_byte};
      ADR_PERIOD:   rdata = {24'h0, period_register};
      ADR_DEADBAND: rdata = {25'h0, deadband_delay_reg};
      ADR_COMPARE:  rdata = {16'h0, compare_value_pair};
      ADR_TSEL:     rdata = {30'h0, timer_three_control};
      ADR_CONFIG:   rdata = {31'h0, alt_pin_map_select};
      ADR_STATUS:   rdata = {29'h0, status};
      ADR_IRQ_EN:   rdata = {29'h0, irq_enable};
      ADR_SHADOW:   rdata = {20'h0, state, duty_shadow};
      default:      rdata = 32'h0;
    endcase
  end

  // Software-written control registers
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      unit_control_reg    <= '0;
      duty_low_byte       <= 8'h0;
      period_register     <= RST_PERIOD;
      deadband_delay_reg  <= 7'h0;
      compare_value_pair  <= 16'h0;
      timer_three_control <= 2'h0;
      alt_pin_map_select  <= 1'b1;
      irq_enable          <= 3'h0;
    end else if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        ADR_CTRL:     unit_control_reg   <= wb_dat_i[7:0];
        ADR_DUTY:     duty_low_byte      <= wb_dat_i[7:0];
        ADR_PERIOD:   period_register    <= wb_dat_i[7:0];
        ADR_DEADBAND: deadband_delay_reg <= wb_dat_i[6:0];
        ADR_COMPARE: begin
          compare_value_pair[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) begin
            compare_value_pair[15:8] <= wb_dat_i[15:8];
          end
        end
        ADR_TSEL:     timer_three_control <= wb_dat_i[1:0];
        ADR_CONFIG:   alt_pin_map_select  <= wb_dat_i[0];
        ADR_IRQ_EN:   irq_enable          <= wb_dat_i[2:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Interrupts: sticky status, set wins over clear
  logic [2:0] clr_mask;   // Bits written one to clear

  assign clr_mask = (wr && wb_sel_i[0] && wb_adr_i == ADR_IRQ_CLR)
                  ? wb_dat_i[2:0] : 3'h0;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status <= 3'h0;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~clr_mask) | ev;
      irq    <= |(status & irq_enable);
    end
  end

  // ==========================================================
  // Mode decode from the live control register
  logic [3:0] mode;     // Mode select field
  logic       pwm_l;    // Any PWM mode
  logic       dual;     // Half-bridge arrangement
  logic       quad;     // Full-bridge arrangement
  logic       special;  // Trigger mode that really triggers

  assign mode    = unit_control_reg.mode_select_field;
  assign pwm_l   = (mode[3:2] == 2'b11);
  assign dual    = pwm_l && unit_control_reg.output_config_field
                   == CFG_HALF;
  assign quad    = pwm_l
                   && unit_control_reg.output_config_field[0];
  // Unit three has no trigger; 1011 then behaves as 1010
  assign special = (mode == MODE_SPECIAL) && (UNIT != 3);

  // ==========================================================
  // Compare and special event trigger
  logic [15:0] cmp_tmr;  // Selected 16-bit timer
  logic        eq;       // Pair equals timer
  logic        eq_prev;  // Equality last cycle
  logic        hit;      // First cycle of a match
  logic        cmp_pin;  // Compare-driven pin level
  logic        tsel3;    // Timer three selected

  assign tsel3   = timer_three_control[TSEL_CCP_BIT];
  assign cmp_tmr = tsel3 ? timer_three_count : timer_one_count;
  assign eq      = !pwm_l && (mode != MODE_OFF)
                   && (compare_value_pair == cmp_tmr);
  // Edge only, so a stalled timer fires once
  assign hit     = eq && !eq_prev;

  // Standard compare pin actions
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      eq_prev <= 1'b0;
      cmp_pin <= 1'b0;
    end else begin
      eq_prev <= eq;
      if (hit) begin
        case (mode)
          MODE_SET:    cmp_pin <= 1'b1;
          MODE_CLEAR:  cmp_pin <= 1'b0;
          MODE_TOGGLE: cmp_pin <= ~cmp_pin;
          default:     cmp_pin <= cmp_pin;
        endcase
      end
    end
  end

  // Trigger pulses to timers and converter
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trig <= '0;
    end else begin
      trig.clr_t1    <= hit && special && !tsel3;
      trig.clr_t3    <= hit && special && tsel3;
      trig.adc_start <= hit && special && (UNIT == 2)
                        && adc_enabled;
      trig.flag_hold <= hit && special && (UNIT == 2);
    end
  end

  // ==========================================================
  // PWM time base and start-up
  logic [7:0] tb_count;  // Selected period timer
  logic       tb_tick;   // Its increment strobe
  logic       boundary;  // Period match on increment
  logic       load_now;  // Buffered load strobe

  assign tb_count = timer_three_control[TSEL_PWM_BIT]
                    ? alt_period_timer : period_timer;
  assign tb_tick  = timer_three_control[TSEL_PWM_BIT]
                    ? alt_period_tick : period_tick;
  assign boundary = tb_tick && (tb_count == period_register);
  assign load_now = boundary && (state != PS_IDLE);

  // Wait for a timer reset before running
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= PS_IDLE;
    end else if (!pwm_l) begin
      state <= PS_IDLE;
    end else begin
      case (state)
        PS_IDLE: state <= PS_WAIT;
        PS_WAIT: if (boundary) begin
          state <= PS_RUN;
        end
        PS_RUN:  state <= PS_RUN;
        default: state <= PS_IDLE;
      endcase
    end
  end

  // Timer clear pulse at the period boundary
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      period_clear <= 2'h0;
    end else if (boundary && pwm_l) begin
      period_clear <= timer_three_control[TSEL_PWM_BIT]
                      ? 2'h2 : 2'h1;
    end else begin
      period_clear <= 2'h0;
    end
  end

  // ==========================================================
  // Double buffers and waveform
  unit_ctrl_t act_ctrl;  // Control in force
  logic [9:0] duty_next; // Duty to load
  logic       duty_match;
  logic       pwm_raw;   // Modulated level, active high
  logic [6:0] db_act;    // Dead-band in force
  logic [6:0] db_cnt;    // Cycles since last edge
  logic       pwm_prev;
  logic       db_ok;     // Dead-band has elapsed

  assign duty_next  = {duty_low_byte,
                       unit_control_reg.duty_lsb};
  // Match one increment ahead: the level is registered, so it drops as
  // the timer reaches the duty value and the high time equals the duty
  assign duty_match = (state == PS_RUN) && tb_tick
                      && ({8'(tb_count + 8'h1), subcycle}
                          == duty_shadow);

  // Control and duty reach the waveform only at a period boundary; pin ownership follows the live registers
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      act_ctrl    <= '0;
      duty_shadow <= 10'h0;
    end else if (load_now) begin
      act_ctrl    <= unit_control_reg;
      duty_shadow <= duty_next;
    end
  end

  // Set at period start unless duty is zero; clear on match.
  // A duty past the period never matches and stays high.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pwm_raw <= 1'b0;
    end else if (state == PS_IDLE) begin
      pwm_raw <= 1'b0;
    end else if (load_now) begin
      pwm_raw <= (duty_next != 10'h0);
    end else if (duty_match) begin
      pwm_raw <= 1'b0;
    end
  end

  // Dead-band register loads at every period boundary outside PS_IDLE and at every duty match
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      db_act <= 7'h0;
    end else if (load_now || duty_match) begin
      db_act <= deadband_delay_reg;
    end
  end

  // Count instruction cycles since the last waveform edge
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pwm_prev <= 1'b0;
      db_cnt   <= 7'h0;
    end else begin
      pwm_prev <= pwm_raw;
      if (pwm_raw != pwm_prev) begin
        db_cnt <= 7'h1;
      end else if (db_cnt != DB_MAX) begin
        db_cnt <= db_cnt + 7'h1;
      end
    end
  end
  // Too long a delay keeps the output off all phase
  assign db_ok = (db_act == 7'h0)
                 || (pwm_raw == pwm_prev && db_cnt >= db_act);

  // ==========================================================
  // Output arrangement and polarity
  logic [3:0] lvl;   // A..D active-high levels
  logic [3:0] low;   // Active-low per output
  logic [3:0] drv;   // Pin levels after polarity

  always_comb begin
    lvl = 4'h0;
    if (state == PS_RUN) begin
      case (act_ctrl.output_config_field)
        CFG_SINGLE: lvl[PIN_A] = pwm_raw;
        CFG_HALF: begin
          lvl[PIN_A] = pwm_raw && db_ok;
          lvl[PIN_B] = !pwm_raw && db_ok;
        end
        CFG_FWD: begin
          lvl[PIN_A] = 1'b1;
          lvl[PIN_D] = pwm_raw;
        end
        CFG_REV: begin
          lvl[PIN_C] = 1'b1;
          lvl[PIN_B] = pwm_raw;
        end
        default: lvl = 4'h0;
      endcase
    end
  end
  // Bit one inverts A and C, bit zero inverts B and D
  assign low = {act_ctrl.mode_select_field[0],
                act_ctrl.mode_select_field[1],
                act_ctrl.mode_select_field[0],
                act_ctrl.mode_select_field[1]};
  assign drv = lvl ^ low;

  // ==========================================================
  // Pin routing; unused pins stay with the port logic, except D, which follows the shared compare unit.
  // Pin direction bits are left to software.
  pins_t next_pins;
  logic  use_b;
  logic  alt;

  assign use_b = dual || quad;
  assign alt   = alt_pin_map_select;

  always_comb begin
    next_pins = '0;
    next_pins.own[PIN_A] = (mode != MODE_OFF);
    next_pins.out[PIN_A] = pwm_l ? drv[PIN_A] : cmp_pin;
    next_pins.own[PIN_B]     = use_b && alt;
    next_pins.own[PIN_B_ALT] = use_b && !alt;
    next_pins.own[PIN_C]     = quad && alt;
    next_pins.own[PIN_C_ALT] = quad && !alt;
    next_pins.out[PIN_B]     = use_b && alt && drv[PIN_B];
    next_pins.out[PIN_B_ALT] = use_b && !alt && drv[PIN_B];
    next_pins.out[PIN_C]     = quad && alt && drv[PIN_C];
    next_pins.out[PIN_C_ALT] = quad && !alt && drv[PIN_C];
    // Quad takes the shared pin from the compare unit
    next_pins.own[PIN_D] = quad || shared_own;
    next_pins.out[PIN_D] = quad ? drv[PIN_D] : shared_out;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  // Event sources for the status register
  assign ev[ST_CMP]  = hit && (mode == MODE_TOGGLE || mode[3:2] == 2'b10);
  assign ev[ST_PER]  = boundary && (state == PS_RUN);
  assign ev[ST_TRIG] = hit && special;

  // ==========================================================
  // Assertions
  property p_quad_own;
    @(posedge clk) disable iff (!rst_sync_n)
    quad |=> pins.own[PIN_D] && pins.own[PIN_A];
  endproperty
  a_quad_own: assert property (p_quad_own)
    else $error("quad mode lost output pins");

  property p_alt_map;
    @(posedge clk) disable iff (!rst_sync_n)
    use_b && !alt |=> pins.own[PIN_B_ALT] && !pins.own[PIN_B];
  endproperty
  a_alt_map: assert property (p_alt_map)
    else $error("output b not on alternate pin");

  property p_shared;
    @(posedge clk) disable iff (!rst_sync_n)
    !quad |=> pins.out[PIN_D] == $past(shared_out);
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared pin not passed through");

  property p_trig;
    @(posedge clk) disable iff (!rst_sync_n)
    hit && special |=> trig.clr_t1 != trig.clr_t3;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger cleared wrong timer");

  property p_adc;
    @(posedge clk) disable iff (!rst_sync_n)
    trig.adc_start |-> $past(adc_enabled) && UNIT == 2;
  endproperty
  a_adc: assert property (p_adc)
    else $error("conversion started while disabled");

  property p_no_u3;
    @(posedge clk) disable iff (!rst_sync_n)
    !special |=> !trig.clr_t1 && !trig.clr_t3 && !trig.adc_start;
  endproperty
  a_no_u3: assert property (p_no_u3)
    else $error("trigger raised outside trigger mode");

  property p_hold;
    @(posedge clk) disable iff (!rst_sync_n)
    (trig.clr_t1 || trig.clr_t3) && UNIT == 2 |-> trig.flag_hold;
  endproperty
  a_hold: assert property (p_hold)
    else $error("timer flag not held off");

  property p_buffer;
    @(posedge clk) disable iff (!rst_sync_n)
    !load_now |=> $stable(act_ctrl) && $stable(duty_shadow);
  endproperty
  a_buffer: assert property (p_buffer)
    else $error("control changed off boundary");

  property p_wait;
    @(posedge clk) disable iff (!rst_sync_n)
    state == PS_WAIT |-> !pwm_raw;
  endproperty
  a_wait: assert property (p_wait)
    else $error("pwm ran before timer reset");

  property p_zero;
    @(posedge clk) disable iff (!rst_sync_n)
    load_now && duty_next == 10'h0 |=> !pwm_raw;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero duty set the output");

  c_run: cover property (@(posedge clk) state == PS_RUN && duty_match);
  c_trig: cover property (@(posedge clk) trig.clr_t3);
  c_half: cover property (@(posedge clk) dual && state == PS_RUN);

endmodule

`default_nettype wire

// ### eccp_driver_model.sv
/*
  Model of the power switch drivers on the A/B leg of the PWM pins.
  Assumes pins come from eccp_core on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module eccp_driver_model
  import eccp_pkg::*;
(
  input  wire logic  clk,
  input  wire pins_t pins,
  output var  int    n_shoot
);
  // ====
  // Shoot-through count
  // Direction bits are cleared by software, so a pin the unit does not
  // own never switches its driver
  initial n_shoot = 0;
  always @(posedge clk) begin
    // Leg B may sit on its primary or its alternate pin
    if (pins.own[PIN_A] && pins.out[PIN_A]
        && ((pins.own[PIN_B] && pins.out[PIN_B])
            || (pins.own[PIN_B_ALT] && pins.out[PIN_B_ALT]))) begin
      n_shoot <= n_shoot + 1;
    end
  end
endmodule

`default_nettype wire

// ### test_enhanced_ccp_trigger_and_pwm_core.sv
/*
  Self-checking bench for eccp_core as unit two.
  Assumes the bench models timer two and the compare timers.
*/
`timescale 1ns/1ps
`default_nettype none

module test_enhanced_ccp_trigger_and_pwm_core;
  import eccp_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  tmr = 8'h00;  // Period timer
  logic [7:0]  per = 8'hff;  // Bench copy of the period
  logic [15:0] t1 = 16'h0;
  logic [15:0] t3 = 16'h0;
  logic        adc_en = 1'b0;
  pins_t       pins;
  trig_t       trig;
  logic [1:0]  pclr;
  logic        irq;
  logic [31:0] seed = 32'h2516ffc0;
  int          n_tr [4] = '{default: 0};  // Trigger pulse counts
  int          n_shoot;
  int          n_mismatch = 0;
  int          check_count = 0;

  // ====
  // Clock, timer two and trigger counters
  always #10 clk = ~clk;
  always @(posedge clk) begin
    tmr <= (tmr == per) ? 8'h00 : tmr + 8'h01;
    for (int i = 0; i < 4; i++) begin
      n_tr[i] <= n_tr[i] + int'(trig[i]);
    end
  end

  eccp_core #(.UNIT(2)) u_eccp_core (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .period_timer(tmr),
    .alt_period_timer(tmr), .period_tick(1'b1),
    .alt_period_tick(1'b0), .subcycle(2'b00), .timer_one_count(t1),
    .timer_three_count(t3), .adc_enabled(adc_en), .shared_out(tmr[0]),
    .shared_own(tmr[1]), .pins(pins), .trig(trig), .period_clear(pclr),
    .irq(irq));

  eccp_driver_model u_eccp_driver_model (
    .clk(clk), .pins(pins), .n_shoot(n_shoot));

  // ====
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Pins owned for an arrangement and pin map
  function automatic logic [5:0] exp_own(input logic [1:0] c,
                                         input logic m,
                                         input logic s);
    logic [5:0] o;
    o = 6'h01;
    o[PIN_D] = s; // Shared compare pin keeps its own owner
    if (c != CFG_SINGLE) o[m ? PIN_B : PIN_B_ALT] = 1'b1;
    if (c[0]) begin
      o[PIN_D] = 1'b1;
      o[m ? PIN_C : PIN_C_ALT] = 1'b1;
    end
    return o;
  endfunction

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // One classic cycle; waits for ack, bench timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog, well above the expected run length
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end

  // ====
  // Main sequence
  initial begin
    int b [4];
    int h;
    int e;
    int s0;
    int hd;
    int g;
    logic [15:0] cv;
    logic [7:0] d;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    wb(0, ADR_PERIOD, 0); chk(32'(RST_PERIOD), rdat);
    wb(0, ADR_CONFIG, 0); chk(32'h1, rdat);
    wb(0, 8'h3c, 0); chk(32'h0, rdat);
    // Trigger on timer one with converter on, then timer three masked
    for (int s = 0; s < 2; s++) begin
      cv = 16'(rnd());
      {t1, t3} <= {~cv, ~cv};
      adc_en <= (s == 0);
      wb(1, ADR_IRQ_EN, s ? 0 : 4);
      wb(1, ADR_TSEL, s);
      wb(1, ADR_COMPARE, cv);
      wb(1, ADR_CTRL, MODE_SPECIAL);
      b = n_tr;
      @(posedge clk);
      if (s) t3 <= cv; else t1 <= cv;
      repeat (5) @(posedge clk);
      chk(32'(n_tr[3] - b[3]), 32'(s == 0));
      chk(32'(n_tr[2] - b[2]), 32'(s));
      chk(32'(n_tr[1] - b[1]), 32'(s == 0));
      chk(32'(n_tr[0] - b[0]), 32'h1);
      chk(32'(irq), 32'(s == 0));
      wb(0, ADR_STATUS, 0); chk(32'(rdat[ST_TRIG]), 32'h1);
      wb(1, ADR_IRQ_CLR, 7);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
    end
    // PWM over every arrangement, both pin maps and polarities
    wb(1, ADR_PERIOD, 32'h0f);
    per <= 8'h0f;
    wb(1, ADR_DEADBAND, 1);
    for (int k = 0; k < 8; k++) begin
      d = 8'((rnd() & 32'h7) + 2);
      wb(1, ADR_CONFIG, k[0]);
      wb(1, ADR_DUTY, d);
      wb(1, ADR_CTRL, {k[2:1], 2'b00, 4'hc | (k[0] ? 4'h3 : 4'h0)});
      repeat (2) begin
        h = 0;
        do begin @(posedge clk); h++; end while (!pclr[0] && h < 600);
      end
      chk(32'(pclr[0]), 32'h1);
      chk(32'(pins.own),
          32'(exp_own(k[2:1], k[0], per[1])));
      e = (k[2:1] == 0) ? d : (k[2:1] == 2) ? d - 1
        : (k[2:1] == 1) ? 16 : 0;
      if (k[0]) e = 16 - e;
      // Output D: modulated in forward, idle in reverse, else the
      // shared pin, which follows timer bit zero (half of a period)
      g = (k[2:1] == 1) ? d : 0;
      if (k[0]) g = 16 - g;
      if (!k[1]) g = 8;
      h = 0;
      hd = 0;
      s0 = n_shoot;
      repeat (16) begin
        @(posedge clk);
        h += int'(pins.out[PIN_A]);
        hd += int'(pins.out[PIN_D]);
      end
      chk(32'(h), 32'(e));
      chk(32'(hd), 32'(g));
      if (!k[0]) chk(32'(n_shoot - s0), 32'h0);
    end
    stop_test();
  end
endmodule

`default_nettype wire
